// ===== hdl/wdg_regs.svh
// Register offsets, field positions, reset values and timing counts of the watchdog
`ifndef WDG_REGS_SVH
`define WDG_REGS_SVH

`define WDG_ADDR_W            12
`define WDG_OFF_UPPER         12'hFF1
`define WDG_OFF_MIDDLE        12'hFF2
`define WDG_OFF_LOW           12'hFF3
`define WDG_OFF_CTRL          12'hFF4
`define WDG_OFF_STATUS        12'hFF5
`define WDG_OFF_MASK          12'hFF6

`define WDG_RST_UPPER         8'h00
`define WDG_RST_MIDDLE        8'h04
`define WDG_RST_LOW           8'h00
`define WDG_RST_CTRL          8'h00
`define WDG_RST_MASK          8'h00

`define WDG_CTRL_RESP_BIT     0
`define WDG_CTRL_STOP_OSC_BIT 1
`define WDG_STAT_TIMEOUT_BIT  0

`define WDG_CNT_TERMINAL      24'h000001
`define WDG_CNT_NO_REFRESH    24'h000002
`define WDG_CNT_ZERO          24'h000000

`define WDG_CORE_CLK_HZ       25000000
`define WDG_OSC_HZ            10000
`define WDG_OSC_DIV           (`WDG_CORE_CLK_HZ / `WDG_OSC_HZ)
`define WDG_OSC_CNT_W         12

`endif

// ===== hdl/wdg_pkg.sv
// Types shared by the watchdog modules
package wdg_pkg;

	typedef enum logic [0:0] {
		WDG_RESP_RESET = 1'b0,
		WDG_RESP_IRQ   = 1'b1
	} wdg_resp_t;

	typedef logic [23:0] wdg_count_t;

endpackage

// ===== hdl/wdg_rcosc.sv
// Stand-in for the dedicated watchdog oscillator: a tick at the oscillator rate
`include "wdg_regs.svh"

module wdg_rcosc
	import wdg_pkg::*;
(
	// Clock and reset
	input  wire logic core_clk,
	input  wire logic rst,
	// Control
	input  wire logic run,
	// Oscillator tick, one cycle
	output logic      osc_tick
);

	localparam logic [`WDG_OSC_CNT_W-1:0] DIV_LAST = `WDG_OSC_CNT_W'(`WDG_OSC_DIV - 1);

	logic [`WDG_OSC_CNT_W-1:0] div_r;
	logic [`WDG_OSC_CNT_W-1:0] div_nxt;
	logic                      tick_r;
	logic                      tick_nxt;

	////////////////////////////////////////////////////////////////////////////////
	// Divider; a stopped oscillator simply freezes its phase
	always_comb begin
		div_nxt  = div_r;
		tick_nxt = 1'b0;
		if (run) begin
			if (div_r == DIV_LAST) begin
				div_nxt  = '0;
				tick_nxt = 1'b1;
			end else begin
				div_nxt = div_r + `WDG_OSC_CNT_W'(1);
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			div_r  <= '0;
			tick_r <= 1'b0;
		end else begin
			div_r  <= div_nxt;
			tick_r <= tick_nxt;
		end
	end

	assign osc_tick = tick_r;

endmodule

// ===== hdl/wdg_top.sv
// Watchdog timer: 24-bit reloadable down-counter with reset or interrupt response
//
// Behaviour
// - Counter steps only on its own oscillator
// - 24-bit down-counter loaded from three bytes
// - Terminal count fires the response once
// - Only on or off; counts once on
// - Enabled by refresh or always-on option
// - Response selectable: reset or interrupt
// - Upper byte is bits 23 to 16
// - Refresh loads reload value into counter
// - Writes set reload, reads show count
// - Refresh ignored at counts 2 and 1, accepted again after time-out
// - Period in ms is reload over ten
// - Counts in STOP; oscillator if enabled
// - Time-out wakes processor from HALT
// - Reset response gives full system reset, or STOP recovery in STOP
// - Middle byte is bits 15 to 8
`include "wdg_regs.svh"

module wdg_top
	import wdg_pkg::*;
(
	// Clock and reset
	input  wire logic                   core_clk,
	input  wire logic                   rst,
	// Register port
	input  wire logic [`WDG_ADDR_W-1:0] reg_addr,
	input  wire logic [7:0]             reg_wdata,
	input  wire logic                   reg_wr,
	input  wire logic                   reg_rd,
	output logic      [7:0]             reg_rdata,
	// Processor side
	input  wire logic                   refresh_instr,
	input  wire logic                   always_on_option,
	input  wire logic                   halt_mode,
	input  wire logic                   stop_mode,
	// Time-out responses
	output logic                        sys_reset_req,
	output logic                        stop_recover_req,
	output logic                        irq_req,
	output logic                        halt_wake,
	output logic                        irq
);

	logic                 osc_tick;
	logic                 osc_run;

	logic [7:0]           ctrl_r,   ctrl_nxt;
	logic [7:0]           status_r, status_nxt;
	logic [7:0]           mask_r,   mask_nxt;
	logic [7:0]           rdata_r,  rdata_nxt;

	wdg_count_t           count_r,  count_nxt;
	logic                 on_r,     on_nxt;
	logic                 expired_r, expired_nxt;
	logic                 rst_req_r, rst_req_nxt;
	logic                 stop_req_r, stop_req_nxt;
	logic                 irq_req_r, irq_req_nxt;
	logic                 wake_r,   wake_nxt;
	logic                 irq_r,    irq_nxt;

	wire wdg_count_t      reload;
	wdg_resp_t            resp;
	logic                 refresh_ok;
	logic                 timeout;

	// Index 2 is the upper byte, so the packed tables read in bit order
	localparam logic [2:0][`WDG_ADDR_W-1:0] BYTE_OFF = {`WDG_OFF_UPPER, `WDG_OFF_MIDDLE,
		`WDG_OFF_LOW};
	localparam logic [2:0][7:0]              BYTE_RST = {`WDG_RST_UPPER, `WDG_RST_MIDDLE,
		`WDG_RST_LOW};

	////////////////////////////////////////////////////////////////////////////////
	// Oscillator: free in run and HALT, in STOP only when allowed
	assign osc_run = !stop_mode || ctrl_r[`WDG_CTRL_STOP_OSC_BIT];

	wdg_rcosc wdg_rcosc_i (
		.core_clk (core_clk),
		.rst      (rst),
		.run      (osc_run),
		.osc_tick (osc_tick)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Reload value and response select
	assign resp   = wdg_resp_t'(ctrl_r[`WDG_CTRL_RESP_BIT]);

	// Near terminal count the refresh is refused so a runaway loop cannot rescue itself
	assign refresh_ok = refresh_instr &&
		(expired_r || (count_r > `WDG_CNT_NO_REFRESH));

	// Each oscillator tick is 0.1 ms at the typical rate, so reload/10 gives ms
	assign timeout = on_r && !expired_r && osc_tick &&
		(count_r == `WDG_CNT_TERMINAL);

	////////////////////////////////////////////////////////////////////////////////
	// Counter and enable
	always_comb begin
		on_nxt      = on_r;
		count_nxt   = count_r;
		expired_nxt = expired_r;
		// The option is sampled from the first cycle after reset release
		if (always_on_option || refresh_instr) begin
			on_nxt = 1'b1;
		end
		if (refresh_ok) begin
			count_nxt   = reload;
			expired_nxt = 1'b0;
		end else if (timeout) begin
			count_nxt   = `WDG_CNT_ZERO;
			expired_nxt = 1'b1;
		end else if (on_r && !expired_r && osc_tick) begin
			count_nxt = count_r - 24'h000001;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			on_r      <= 1'b0;
			count_r   <= {`WDG_RST_UPPER, `WDG_RST_MIDDLE, `WDG_RST_LOW};
			expired_r <= 1'b0;
		end else begin
			on_r      <= on_nxt;
			count_r   <= count_nxt;
			expired_r <= expired_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Time-out responses, one cycle each
	always_comb begin
		rst_req_nxt  = timeout && (resp == WDG_RESP_RESET) && !stop_mode;
		stop_req_nxt = timeout && (resp == WDG_RESP_RESET) && stop_mode;
		irq_req_nxt  = timeout && (resp == WDG_RESP_IRQ);
		wake_nxt     = timeout && halt_mode;
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			rst_req_r  <= 1'b0;
			stop_req_r <= 1'b0;
			irq_req_r  <= 1'b0;
			wake_r     <= 1'b0;
		end else begin
			rst_req_r  <= rst_req_nxt;
			stop_req_r <= stop_req_nxt;
			irq_req_r  <= irq_req_nxt;
			wake_r     <= wake_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Reload bytes, one per entry; each is written alone, with no staging latch
	for (genvar b = 0; b < 3; b++) begin : g_reload
		logic [7:0] byte_r;
		logic [7:0] byte_nxt;

		always_comb begin
			byte_nxt = byte_r;
			if (reg_wr && (reg_addr == BYTE_OFF[b])) begin
				byte_nxt = reg_wdata;
			end
		end

		always_ff @(posedge core_clk) begin
			if (rst) begin
				byte_r <= BYTE_RST[b];
			end else begin
				byte_r <= byte_nxt;
			end
		end

		assign reload[8*b +: 8] = byte_r;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Control and mask; unused bits are held at zero
	always_comb begin
		ctrl_nxt = ctrl_r;
		mask_nxt = mask_r;
		if (reg_wr && (reg_addr == `WDG_OFF_CTRL)) begin
			ctrl_nxt = reg_wdata & 8'h03;
		end
		if (reg_wr && (reg_addr == `WDG_OFF_MASK)) begin
			mask_nxt = reg_wdata & 8'h01;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			ctrl_r <= `WDG_RST_CTRL;
			mask_r <= `WDG_RST_MASK;
		end else begin
			ctrl_r <= ctrl_nxt;
			mask_r <= mask_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Status and interrupt level
	always_comb begin
		status_nxt = status_r;
		if (reg_wr && (reg_addr == `WDG_OFF_STATUS)) begin
			status_nxt = status_r & ~(reg_wdata & 8'h01);
		end
		// Set after clear, so an event in the clearing cycle survives
		if (timeout) begin
			status_nxt[`WDG_STAT_TIMEOUT_BIT] = 1'b1;
		end
		irq_nxt = |(status_nxt & mask_nxt);
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			status_r <= 8'h00;
			irq_r    <= 1'b0;
		end else begin
			status_r <= status_nxt;
			irq_r    <= irq_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read data: one cycle after the strobe, zero otherwise
	always_comb begin
		rdata_nxt = 8'h00;
		if (reg_rd) begin
			unique case (reg_addr)
				`WDG_OFF_UPPER:  rdata_nxt = count_r[23:16];
				`WDG_OFF_MIDDLE: rdata_nxt = count_r[15:8];
				`WDG_OFF_LOW:    rdata_nxt = count_r[7:0];
				`WDG_OFF_CTRL:   rdata_nxt = ctrl_r;
				`WDG_OFF_STATUS: rdata_nxt = status_r;
				`WDG_OFF_MASK:   rdata_nxt = mask_r;
				default:         rdata_nxt = 8'h00;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			rdata_r <= 8'h00;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs
	assign reg_rdata        = rdata_r;
	assign sys_reset_req    = rst_req_r;
	assign stop_recover_req = stop_req_r;
	assign irq_req          = irq_req_r;
	assign halt_wake        = wake_r;
	assign irq              = irq_r;

endmodule

// ===== sim/wdg_top_assertions.sv
// Port checks of the watchdog
`include "wdg_regs.svh"
module wdg_top_chk (
	// Clock and reset
	input wire logic                   core_clk,
	input wire logic                   rst,
	// Register port
	input wire logic [`WDG_ADDR_W-1:0] reg_addr,
	input wire logic                   reg_wr,
	input wire logic                   reg_rd,
	input wire logic [7:0]             reg_rdata,
	// Modes and responses
	input wire logic                   stop_mode,
	input wire logic                   sys_reset_req,
	input wire logic                   stop_recover_req,
	input wire logic                   irq_req,
	input wire logic                   halt_wake,
	input wire logic                   irq
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data not idle");
	a_unmapped_read: assert property (reg_rd && (reg_addr < `WDG_OFF_UPPER ||
		reg_addr > `WDG_OFF_MASK) |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_one_response: assert property ($onehot0({sys_reset_req, stop_recover_req, irq_req}))
		else $error("two responses at once");
	a_irq_once: assert property (irq_req |=> !irq_req [*8])
		else $error("interrupt request repeated");
	a_reset_once: assert property (sys_reset_req |=> !sys_reset_req [*8])
		else $error("reset request repeated");
	a_wake_cause: assert property (halt_wake |-> sys_reset_req || stop_recover_req || irq_req)
		else $error("wake without time-out");
	a_stop_route: assert property (stop_mode && $past(stop_mode) |-> !sys_reset_req)
		else $error("system reset during stop");
	a_irq_fall: assert property ($fell(irq) |-> $past(reg_wr) || $past(reg_wr, 2))
		else $error("interrupt dropped without write");
endmodule
bind wdg_top wdg_top_chk wdg_top_chk_i (.core_clk, .rst, .reg_addr, .reg_wr, .reg_rd,
	.reg_rdata, .stop_mode, .sys_reset_req, .stop_recover_req, .irq_req, .halt_wake, .irq);

// ===== sim/wdg_top_tb.sv
// Self-checking bench of the watchdog
`include "wdg_regs.svh"
module wdg_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin miscompares++; \
	$display("wrong value at %0t: %h expected %h", $time, g, e); end end
	logic        core_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, refresh_instr = 0;
	logic        always_on_option = 0, halt_mode = 0, stop_mode = 0;
	logic [11:0] reg_addr = 0;
	logic [7:0]  reg_wdata = 0, reg_rdata;
	logic        sys_reset_req, stop_recover_req, irq_req, halt_wake, irq;
	int          miscompares = 0, cmp_count = 0, cycles = 0, n;
	////////////////////
	always #20 core_clk = ~core_clk;
	// Ceiling well above the three time-outs and two idle periods
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 60000) begin
			miscompares++;
			stop_test;
		end
	end
	wdg_top wdg_top_i (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.refresh_instr, .always_on_option, .halt_mode, .stop_mode, .sys_reset_req,
		.stop_recover_req, .irq_req, .halt_wake, .irq);
	////////////////////
	task wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task rd(input logic [11:0] a, input logic [7:0] e);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		// Looked at on the edge that ends its one cycle
		@(posedge core_clk);
		`CHK(reg_rdata, e)
	endtask
	// Reload bytes then a refresh
	task load(input logic [23:0] v);
		wr(`WDG_OFF_UPPER, v[23:16]);
		wr(`WDG_OFF_MIDDLE, v[15:8]);
		wr(`WDG_OFF_LOW, v[7:0]);
		refresh;
	endtask
	task refresh;
		@(posedge core_clk);
		refresh_instr <= 1'b1;
		@(posedge core_clk);
		refresh_instr <= 1'b0;
	endtask
	// Pulses last one cycle, so every cycle is looked at
	task wait_resp(input logic [3:0] e);
		n = 0;
		while (!(sys_reset_req | stop_recover_req | irq_req) && n < 12000) begin
			@(posedge core_clk);
			n++;
		end
		`CHK({halt_wake, stop_recover_req, irq_req, sys_reset_req}, e)
	endtask
	task stop_test;
		if (miscompares == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	////////////////////
	initial begin
		repeat (20) @(posedge core_clk);
		rst <= 1'b0;
		repeat (2600) @(posedge core_clk);
		rd(`WDG_OFF_MIDDLE, 8'h04);
		rd(`WDG_OFF_LOW, 8'h00);
		rd(12'hFF0, 8'h00);
		load(24'h123456);
		rd(`WDG_OFF_UPPER, 8'h12);
		rd(`WDG_OFF_MIDDLE, 8'h34);
		wr(`WDG_OFF_CTRL, 8'h01);
		wr(`WDG_OFF_MASK, 8'h01);
		halt_mode <= 1'b1;
		load(24'h000004);
		rd(`WDG_OFF_LOW, 8'h04);
		wait_resp(4'hA);
		`CHK(n > 7480 && n < 10010, 1'b1)
		rd(`WDG_OFF_LOW, 8'h00);
		rd(`WDG_OFF_STATUS, 8'h01);
		`CHK(irq, 1'b1)
		wr(`WDG_OFF_STATUS, 8'h01);
		rd(`WDG_OFF_STATUS, 8'h00);
		`CHK(irq, 1'b0)
		halt_mode <= 1'b0;
		wr(`WDG_OFF_CTRL, 8'h00);
		load(24'h000004);
		// Two ticks later the count stands at 2, so a refresh must be refused
		repeat (5100) @(posedge core_clk);
		rd(`WDG_OFF_LOW, 8'h02);
		refresh;
		rd(`WDG_OFF_LOW, 8'h02);
		wait_resp(4'h1);
		wr(`WDG_OFF_CTRL, 8'h02);
		stop_mode <= 1'b1;
		load(24'h000004);
		wait_resp(4'h4);
		stop_mode <= 1'b0;
		always_on_option <= 1'b1;
		rst <= 1'b1;
		repeat (20) @(posedge core_clk);
		rst <= 1'b0;
		repeat (2600) @(posedge core_clk);
		rd(`WDG_OFF_MIDDLE, 8'h03);
		rd(`WDG_OFF_LOW, 8'hFF);
		stop_test;
	end
endmodule
